// file: rtl/acr_pkg.sv
// acr_pkg: register map, field layout, reset values and frame timing
// assumes: 32-bit Avalon-MM byte addresses, 256-bit link frames
package acr_pkg;
  // ********************
  // register map
  // ********************
  localparam logic [31:0] LINK_CONTROL_ADDR = 32'hfff0902c;
  localparam logic [31:0] OUT_TAG_ADDR      = 32'hfff09030;
  localparam logic [31:0] OUT_CMD_ADDR_ADDR = 32'hfff09034;
  localparam logic [31:0] OUT_CMD_DATA_ADDR = 32'hfff09038;
  localparam logic [31:0] IN_TAG_ADDR       = 32'hfff0903c;
  localparam logic [31:0] IN_READ_DATA_ADDR = 32'hfff09044;

  // ********************
  // fields and reset values
  // ********************
  localparam int          TAG_W        = 5;
  localparam int          CMD_ADDR_W   = 8;
  localparam int          WORD_W       = 16;
  localparam int          PENDING_BIT  = 3;
  localparam int          READY_BIT    = 4;
  localparam int          RW_SEL_BIT   = 7;
  localparam logic [4:0]  TAG_RST      = 5'h00;
  localparam logic [7:0]  CMD_ADDR_RST = 8'h80;
  localparam logic [15:0] CMD_DATA_RST = 16'h0000;
  localparam logic [31:0] ZERO_WORD    = 32'h00000000;

  // ********************
  // frame timing in bit clocks
  // ********************
  localparam int         CNT_W       = 8;
  localparam logic [7:0] FRAME_LAST  = 8'hff;
  localparam logic [7:0] TAG_FIRST   = 8'h01;
  localparam logic [7:0] TAG_END     = 8'h05;
  localparam logic [7:0] SLOT1_FIRST = 8'h10;
  localparam logic [7:0] SLOT1_END   = 8'h18;
  localparam logic [7:0] SLOT2_FIRST = 8'h24;
  localparam logic [7:0] SLOT2_END   = 8'h34;
  localparam logic [7:0] SYNC_END    = 8'h10;
  localparam logic [7:0] IN_TAG_AT   = 8'h10;
  localparam logic [7:0] IN_RD_AT    = 8'h34;

  typedef enum logic {BUS_IDLE, BUS_ANSWER} acr_bus_t;
endpackage

// file: rtl/acr_xfer_if.sv
// acr_xfer_if: words and toggles passed between bus and link domains
// assumes: words stay stable while their toggle is in flight
`timescale 1ns/100ps
interface acr_xfer_if;
  logic        cmdReq;    // toggles per queued command (bus side)
  logic [4:0]  cmdTag;    // outgoing tag snapshot
  logic [7:0]  cmdAddr;   // select and index snapshot
  logic [15:0] cmdData;   // write word snapshot
  logic        cmdAck;    // toggles when command sent (link side)
  logic [4:0]  inTag;     // received tag bits
  logic        inTagTgl;  // toggles per received tag
  logic [15:0] rdData;    // returned read word
  logic        rdTgl;     // toggles per returned word
  modport sys  (output cmdReq, cmdTag, cmdAddr, cmdData,
                input  cmdAck, inTag, inTagTgl, rdData, rdTgl);
  modport link (input  cmdReq, cmdTag, cmdAddr, cmdData,
                output cmdAck, inTag, inTagTgl, rdData, rdTgl);
endinterface

// file: rtl/acr_sync.sv
// acr_sync: two-flop synchroniser, one per bit
// assumes: each bit is a level or toggle held over several dest clocks
`timescale 1ns/100ps
module acr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,    // destination clock
  input  wire logic             reset,  // async, active high
  input  wire logic [WIDTH-1:0] din,    // foreign-domain input
  output logic      [WIDTH-1:0] dout    // synchronised level
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= '0;
      dout     <= '0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule

// file: rtl/acr_link_engine.sv
// acr_link_engine: frame counter, slot 0-2 shifter and tag capture
// assumes: codec bit clock runs free; bus side holds words while pending
`timescale 1ns/100ps
module acr_link_engine
  import acr_pkg::*;
(
  input  wire logic linkClk,   // bit clock from codec
  input  wire logic reset,     // async, active high
  input  wire logic sdataIn,   // serial data from codec
  output logic      sdataOut,  // serial data to codec
  output logic      syncOut,   // frame sync to codec
  acr_xfer_if.link  xl         // words to and from bus domain
);
  logic             linkRun;
  logic             reqSeen;
  logic [CNT_W-1:0] bitCnt_reg;
  logic             active_reg;
  logic             ack_reg;
  logic             readExp_reg;
  logic [19:0]      shiftIn_reg;
  logic [4:0]       inTag_reg;
  logic             inTagTgl_reg;
  logic [15:0]      rdData_reg;
  logic             rdTgl_reg;
  logic             outBit;
  wire logic        linkRst = ~linkRun;
  wire logic        frameEnd = bitCnt_reg == FRAME_LAST;
  wire logic [19:0] curIn = {shiftIn_reg[18:0], sdataIn};

  // ********************
  // reset release and request crossing
  // ********************
  // release is synchronous to the bit clock so no flop sees a runt edge
  acr_sync #(.WIDTH(1)) u_rst (.clk(linkClk), .reset(reset), .din(1'b1), .dout(linkRun));
  acr_sync #(.WIDTH(1)) u_req (.clk(linkClk), .reset(linkRst), .din(xl.cmdReq), .dout(reqSeen));

  // ********************
  // outgoing frame bits
  // ********************
  always_comb begin
    outBit = 1'b0;
    if (active_reg) begin
      if (bitCnt_reg == '0) begin
        outBit = xl.cmdTag[4]; // RL1 RL3
      end else if (bitCnt_reg < TAG_END) begin
        outBit = xl.cmdTag[2'(bitCnt_reg - TAG_FIRST)]; // RL4
      end else if (bitCnt_reg >= SLOT1_FIRST && bitCnt_reg < SLOT1_END) begin
        outBit = xl.cmdAddr[3'(SLOT1_END - 8'h01 - bitCnt_reg)]; // RL5 RL6 RL7
      end else if (bitCnt_reg >= SLOT2_FIRST && bitCnt_reg < SLOT2_END) begin
        outBit = xl.cmdData[4'(SLOT2_END - 8'h01 - bitCnt_reg)]; // RL6 RL8
      end
    end
  end

  always_ff @(posedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      bitCnt_reg <= '0;
      sdataOut   <= 1'b0;
      syncOut    <= 1'b0;
    end else begin
      bitCnt_reg <= bitCnt_reg + 8'h01;
      sdataOut   <= outBit;
      syncOut    <= bitCnt_reg < SYNC_END;
    end
  end

  // ********************
  // command sequencing per frame
  // ********************
  // a command occupies exactly one frame; idle frames go out all zero
  always_ff @(posedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      active_reg  <= 1'b0;
      ack_reg     <= 1'b0;
      readExp_reg <= 1'b0;
    end else if (frameEnd) begin
      active_reg  <= reqSeen != (ack_reg ^ active_reg);
      ack_reg     <= ack_reg ^ active_reg; // RL12
      readExp_reg <= active_reg & xl.cmdAddr[RW_SEL_BIT]; // RL5
    end
  end

  // ********************
  // incoming tag and read word
  // ********************
  always_ff @(posedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      shiftIn_reg  <= '0;
      inTag_reg    <= TAG_RST;
      inTagTgl_reg <= 1'b0;
      rdData_reg   <= CMD_DATA_RST;
      rdTgl_reg    <= 1'b0;
    end else begin
      shiftIn_reg <= curIn;
      if (bitCnt_reg == IN_TAG_AT) begin
        inTag_reg    <= {curIn[15], curIn[11], curIn[12], curIn[13], curIn[14]}; // RL9 RL10 RL11
        inTagTgl_reg <= ~inTagTgl_reg;
      end
      if (bitCnt_reg == IN_RD_AT && readExp_reg) begin
        rdData_reg <= curIn[15:0]; // RL13
        rdTgl_reg  <= ~rdTgl_reg;
      end
    end
  end

  assign xl.cmdAck   = ack_reg;
  assign xl.inTag    = inTag_reg;
  assign xl.inTagTgl = inTagTgl_reg;
  assign xl.rdData   = rdData_reg;
  assign xl.rdTgl    = rdTgl_reg;
endmodule

// file: rtl/acr_command_slot_regs.sv
// acr_command_slot_regs: command and tag slot registers of the audio link
// assumes: Avalon-MM master on sys_clk; codec drives the bit clock
//
// Function
// RL1 - software-written outgoing tag goes out in slot 0; resets to zero
// RL2 - software checks command pending before tag write; write while pending ignored
// RL3 - outgoing tag bit 4 marks the frame valid, read/write
// RL4 - outgoing tag bits 3..0 mark slots 4..1 valid, bit 0 is slot 1
// RL5 - select bit 7 set issues a codec read; data returns next frame
// RL6 - select bit clear issues a codec write using the slot 2 word
// RL7 - slot 1 bits 6..0 hold the codec register index, read/write
// RL8 - slot 2 holds the 16-bit write word, shifted out in slot 2
// RL9 - incoming slot 0 tag captured each frame into read-only register
// RL10 - incoming tag bit 4 reports codec ready
// RL11 - incoming tag bits 3..0 report valid received slots 1..4
// RL12 - pending flag sets on tag write, clears once command shifted out
// RL13 - read-ready flag sets on returned data, clears when CPU reads it
// RL14 - reserved bits read zero, writes to them ignored
`timescale 1ns/100ps
module acr_command_slot_regs
  import acr_pkg::*;
(
  input  wire logic        sys_clk,          // bus clock
  input  wire logic        reset,            // async, active high
  input  wire logic [31:0] avs_address,      // byte address
  input  wire logic        avs_read,         // read request
  input  wire logic        avs_write,        // write request
  input  wire logic [31:0] avs_writedata,    // write data
  input  wire logic [3:0]  avs_byteenable,   // byte lanes
  output logic      [31:0] avs_readdata,     // read data, registered
  output logic             avs_waitrequest,  // stall until answered
  input  wire logic        acBitClk,         // bit clock from codec
  input  wire logic        acSdataIn,        // serial data from codec
  output logic             acSdataOut,       // serial data to codec
  output logic             acSync            // frame sync to codec
);
  acr_xfer_if xif ();

  acr_bus_t    busState_reg;
  acr_bus_t    busState_next;
  logic [4:0]  outTag_reg;
  logic [7:0]  outAddr_reg;
  logic [15:0] outData_reg;
  logic [4:0]  inTag_reg;
  logic [15:0] rdData_reg;
  logic        pending_reg;
  logic        pending_next;
  logic        readReady_reg;
  logic        readReady_next;
  logic [4:0]  cmdTag_reg;
  logic [7:0]  cmdAddr_reg;
  logic [15:0] cmdData_reg;
  logic        cmdReq_reg;
  logic [2:0]  syncSeen;
  logic [2:0]  syncPrev_reg;
  logic [31:0] readMux;

  // ********************
  // byte-lane write merge
  // ********************
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wdata,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ********************
  // bus decode
  // ********************
  wire logic hitCtl   = avs_address == LINK_CONTROL_ADDR;
  wire logic hitTag   = avs_address == OUT_TAG_ADDR;
  wire logic hitAddr  = avs_address == OUT_CMD_ADDR_ADDR;
  wire logic hitData  = avs_address == OUT_CMD_DATA_ADDR;
  wire logic hitInTag = avs_address == IN_TAG_ADDR;
  wire logic hitRd    = avs_address == IN_READ_DATA_ADDR;
  wire logic busReq   = avs_read | avs_write;
  wire logic accept   = busReq & (busState_reg == BUS_ANSWER);
  wire logic wrAccept = accept & avs_write;
  wire logic wrTag    = wrAccept & hitTag & ~pending_reg; // RL2
  wire logic wrAddr   = wrAccept & hitAddr;
  wire logic wrData   = wrAccept & hitData;
  wire logic rdClear  = accept & avs_read & hitRd; // RL13

  // reserved bits fall away here since only the field widths are kept
  wire logic [31:0] tagMerged  = laneMerge({27'h0, outTag_reg}, avs_writedata, avs_byteenable);
  wire logic [31:0] addrMerged = laneMerge({24'h000000, outAddr_reg}, avs_writedata, avs_byteenable);
  wire logic [31:0] dataMerged = laneMerge({16'h0000, outData_reg}, avs_writedata, avs_byteenable);

  // ********************
  // crossing from the link domain
  // ********************
  wire logic ackEdge   = syncSeen[2] ^ syncPrev_reg[2];
  wire logic inTagEdge = syncSeen[1] ^ syncPrev_reg[1];
  wire logic rdEdge    = syncSeen[0] ^ syncPrev_reg[0];

  acr_sync #(.WIDTH(3)) u_sync (
    .clk   (sys_clk),
    .reset (reset),
    .din   ({xif.cmdAck, xif.inTagTgl, xif.rdTgl}),
    .dout  (syncSeen)
  );

  acr_link_engine u_link (
    .linkClk  (acBitClk),
    .reset    (reset),
    .sdataIn  (acSdataIn),
    .sdataOut (acSdataOut),
    .syncOut  (acSync),
    .xl       (xif.link)
  );

  // ********************
  // Avalon answer
  // ********************
  // one wait cycle on every access so read data always comes from a flop
  assign avs_waitrequest = busReq & (busState_reg != BUS_ANSWER);

  always_comb begin
    case (busState_reg)
      BUS_IDLE:   busState_next = busReq ? BUS_ANSWER : BUS_IDLE;
      BUS_ANSWER: busState_next = BUS_IDLE;
      default:    busState_next = BUS_IDLE;
    endcase
  end

  always_comb begin
    readMux = ZERO_WORD; // RL14
    if (hitCtl) begin
      readMux[PENDING_BIT] = pending_reg;
      readMux[READY_BIT]   = readReady_reg;
    end else if (hitTag) begin
      readMux[4:0] = outTag_reg; // RL3 RL4
    end else if (hitAddr) begin
      readMux[7:0] = outAddr_reg; // RL7
    end else if (hitData) begin
      readMux[15:0] = outData_reg; // RL8
    end else if (hitInTag) begin
      readMux[4:0] = inTag_reg; // RL10 RL11
    end else if (hitRd) begin
      readMux[15:0] = rdData_reg;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      busState_reg <= BUS_IDLE;
      avs_readdata <= ZERO_WORD;
    end else begin
      busState_reg <= busState_next;
      if (busState_reg == BUS_IDLE && avs_read) begin
        avs_readdata <= readMux;
      end
    end
  end

  // ********************
  // software registers
  // ********************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      outTag_reg  <= TAG_RST; // RL1
      outAddr_reg <= CMD_ADDR_RST;
      outData_reg <= CMD_DATA_RST;
    end else begin
      if (wrTag) begin
        outTag_reg <= tagMerged[4:0]; // RL1 RL3 RL4 RL14
      end
      if (wrAddr) begin
        outAddr_reg <= addrMerged[7:0]; // RL5 RL6 RL7 RL14
      end
      if (wrData) begin
        outData_reg <= dataMerged[15:0]; // RL8 RL14
      end
    end
  end

  // ********************
  // command hand-off and flags
  // ********************
  // set wins over clear on both flags
  assign pending_next   = wrTag | (pending_reg & ~ackEdge); // RL12
  assign readReady_next = rdEdge | (readReady_reg & ~rdClear); // RL13

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pending_reg   <= 1'b0;
      readReady_reg <= 1'b0;
      syncPrev_reg  <= '0;
    end else begin
      pending_reg   <= pending_next;
      readReady_reg <= readReady_next;
      syncPrev_reg  <= syncSeen;
    end
  end

  // snapshot holds still for the link domain until the ack returns
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cmdTag_reg  <= TAG_RST;
      cmdAddr_reg <= CMD_ADDR_RST;
      cmdData_reg <= CMD_DATA_RST;
      cmdReq_reg  <= 1'b0;
    end else if (wrTag) begin
      cmdTag_reg  <= tagMerged[4:0]; // RL1
      cmdAddr_reg <= outAddr_reg; // RL5 RL6
      cmdData_reg <= outData_reg; // RL6
      cmdReq_reg  <= ~cmdReq_reg; // RL12
    end
  end

  assign xif.cmdTag  = cmdTag_reg;
  assign xif.cmdAddr = cmdAddr_reg;
  assign xif.cmdData = cmdData_reg;
  assign xif.cmdReq  = cmdReq_reg;

  // ********************
  // captured link words
  // ********************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      inTag_reg  <= TAG_RST;
      rdData_reg <= CMD_DATA_RST;
    end else begin
      if (inTagEdge) begin
        inTag_reg <= xif.inTag; // RL9
      end
      if (rdEdge) begin
        rdData_reg <= xif.rdData; // RL13
      end
    end
  end
endmodule

// file: sim/acr_command_slot_checker.sv
// acr_command_slot_checker: port assertions for the command slot registers
// assumes: bound to acr_command_slot_regs; sees only its ports
`timescale 1ns/100ps
module acr_command_slot_checker
  import acr_pkg::*;
(
  input wire logic        sys_clk,          // bus clock
  input wire logic        reset,            // async, high
  input wire logic [31:0] avs_address,      // address
  input wire logic        avs_read,         // read
  input wire logic        avs_write,        // write
  input wire logic [31:0] avs_writedata,    // write data
  input wire logic [3:0]  avs_byteenable,   // lanes
  input wire logic [31:0] avs_readdata,     // read data
  input wire logic        avs_waitrequest,  // stall
  input wire logic        acBitClk,         // bit clock
  input wire logic        acSdataIn,        // codec data
  input wire logic        acSdataOut,       // link data
  input wire logic        acSync            // frame sync
);
  // ********************
  // frame position tracking
  // ********************
  logic [7:0] posCnt;
  logic       framed;
  logic       syncD;
  logic       rdDone;
  assign rdDone = avs_read && !avs_waitrequest;
  always_ff @(posedge acBitClk or posedge reset) begin
    if (reset) begin
      posCnt <= 8'h00;
      framed <= 1'b0;
      syncD  <= 1'b0;
    end else begin
      syncD  <= acSync;
      framed <= framed || (acSync && !syncD);
      posCnt <= (acSync && !syncD) ? 8'h01 : posCnt + 8'h01;
    end
  end
  // ********************
  // assertions
  // ********************
  wait_one_a: assert property (@(posedge sys_clk) disable iff (reset)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("wait not one cycle");
  rdata_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    !avs_read |=> $stable(avs_readdata)) else $error("read data moved");
  tag_resv_a: assert property (@(posedge sys_clk) disable iff (reset)
    rdDone && avs_address == OUT_TAG_ADDR |-> avs_readdata[31:5] == 27'h0) else $error("tag reserved set");
  cmd_resv_a: assert property (@(posedge sys_clk) disable iff (reset)
    rdDone && avs_address == OUT_CMD_ADDR_ADDR |-> avs_readdata[31:8] == 24'h0) else $error("addr reserved set");
  data_resv_a: assert property (@(posedge sys_clk) disable iff (reset)
    rdDone && avs_address == OUT_CMD_DATA_ADDR |-> avs_readdata[31:16] == 16'h0) else $error("data reserved set");
  intag_resv_a: assert property (@(posedge sys_clk) disable iff (reset)
    rdDone && avs_address == IN_TAG_ADDR |-> avs_readdata[31:5] == 27'h0) else $error("in tag reserved set");
  pending_set_a: assert property (@(posedge sys_clk) disable iff (reset)
    (avs_write && !avs_waitrequest && avs_address == OUT_TAG_ADDR) ##2
    (avs_read && avs_address == LINK_CONTROL_ADDR)[*2] |-> avs_readdata[PENDING_BIT]) else $error("pending not set");
  ready_clr_a: assert property (@(posedge sys_clk) disable iff (reset)
    (rdDone && avs_address == IN_READ_DATA_ADDR) ##2
    (avs_read && avs_address == LINK_CONTROL_ADDR)[*2] |-> !avs_readdata[READY_BIT]) else $error("ready not cleared");
  sync_width_a: assert property (@(posedge acBitClk) disable iff (reset)
    $rose(acSync) |-> acSync[*8] ##1 acSync[*8] ##1 !acSync) else $error("sync width wrong");
  frame_len_a: assert property (@(posedge acBitClk) disable iff (reset)
    $rose(acSync) && framed |-> posCnt == 8'h00) else $error("frame length wrong");
  pad_zero_a: assert property (@(posedge acBitClk) disable iff (reset)
    framed && (posCnt inside {[8'h05:8'h0f], [8'h18:8'h23], [8'h34:8'hff]}) |-> !acSdataOut)
    else $error("pad bit set");
endmodule

bind acr_command_slot_regs acr_command_slot_checker chk (.sys_clk, .reset, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .acBitClk,
  .acSdataIn, .acSdataOut, .acSync);

// file: sim/acr_codec_model.sv
// acr_codec_model: behavioural codec at the far end of the audio link
// assumes: design changes sync and data after rising bit clock edges
`timescale 1ns/100ps
module acr_codec_model (
  output logic             bitClk,   // free-running bit clock
  input  wire logic        sync,     // frame sync
  input  wire logic        sdOut,    // data from design
  output logic             sdIn,     // data to design
  input  wire logic [4:0]  inTag,    // tag to report
  input  wire logic [15:0] rdWord,   // word for reads
  output logic      [4:0]  outTag,   // command tag seen
  output logic      [7:0]  outAddr,  // select and index seen
  output logic      [15:0] outData,  // write word seen
  output logic             frmTgl,   // toggles per command
  output int               frmCnt    // frames seen
);
  logic [0:255] rx;
  logic [7:0]   pos;
  logic [7:0]   nxt;
  logic         syncD;
  logic         rdNext;
  logic         rdAns;
  initial begin
    {bitClk, syncD, rdNext, rdAns, frmTgl, sdIn} = 6'h00;
    pos = 8'h00;
    frmCnt = 0;
    #7;
    forever #15 bitClk = ~bitClk;
  end
  // ********************
  // capture outgoing slots 0..2
  // ********************
  always @(posedge bitClk) begin
    pos = (sync && !syncD) ? 8'h00 : pos + 8'h01;
    syncD = sync;
    rx[pos] = sdOut;
    if (pos == 8'h34) begin
      outTag = {rx[0], rx[4], rx[3], rx[2], rx[1]};
      outAddr = rx[16:23];
      outData = rx[36:51];
      rdNext = (outTag != 5'h00) && outAddr[7];
      frmCnt++;
      if (outTag != 5'h00) frmTgl = ~frmTgl;
    end
    if (pos == 8'hff) begin
      rdAns = rdNext;
      rdNext = 1'b0;
    end
  end
  // answer drives half a bit early so the design's sample is clean
  always @(negedge bitClk) begin
    nxt = pos + 8'h01;
    if (nxt == 8'h00) sdIn <= inTag[4];
    else if (nxt <= 8'h04) sdIn <= inTag[nxt - 8'h01];
    else if (rdAns && nxt >= 8'h24 && nxt <= 8'h33) sdIn <= rdWord[8'h33 - nxt];
    else sdIn <= 1'b0;
  end
endmodule

// file: sim/tb_top.sv
// tb_top: register and link test of the command slot block
// assumes: codec model makes the bit clock and answers reads
`timescale 1ns/100ps
module tb_top
  import acr_pkg::*;
;
  logic        sys_clk, reset, avs_read, avs_write, avs_waitrequest;
  logic        acBitClk, acSdataIn, acSdataOut, acSync, frmTgl;
  logic [31:0] avs_address, avs_writedata, avs_readdata, d, v, ev, em;
  logic [3:0]  avs_byteenable;
  logic [4:0]  inTag, outTag, t;
  logic [7:0]  outAddr, a;
  logic [15:0] rdWord, outData, dw;
  logic [63:0] busQ[$];
  logic [28:0] linkQ[$];
  int          miscompares, total_checks, cyc, frmCnt, n, c;

  acr_command_slot_regs dut (.sys_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .acBitClk, .acSdataIn, .acSdataOut, .acSync);
  acr_codec_model codec (.bitClk(acBitClk), .sync(acSync), .sdOut(acSdataOut), .sdIn(acSdataIn),
    .inTag, .rdWord, .outTag, .outAddr, .outData, .frmTgl, .frmCnt);

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // ********************
  // bus master and result watchers
  // ********************
  task automatic bus(input logic wr, input logic [31:0] ad, wd, e, m, output logic [31:0] rdv);
    int k;
    k = 0;
    if (!wr) busQ.push_back({e, m});
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= ad;
    avs_writedata <= wd;
    avs_byteenable <= (ad == OUT_CMD_DATA_ADDR && wd[31]) ? 4'h1 : 4'hf;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 40);
    if (k >= 40) miscompares++;
    rdv = avs_readdata;
    // release on the completing edge, then let one edge pass before the next request
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task wr(input logic [31:0] ad, wd);
    bus(1'b1, ad, wd, 32'h0, 32'h0, d);
  endtask
  task rd(input logic [31:0] ad, e, m);
    bus(1'b0, ad, 32'h0, e, m, d);
  endtask
  always @(posedge sys_clk) begin
    if (avs_read && !avs_waitrequest) begin
      {ev, em} = busQ.pop_front();
      total_checks++;
      if ((avs_readdata & em) !== (ev & em)) begin
        miscompares++;
        $display("wrong value at %0t: got %h expected %h", $time, avs_readdata & em, ev & em);
      end
    end
  end
  always @(frmTgl) begin
    if ($time > 0) begin
      total_checks++;
      if (linkQ.size() == 0 || {outTag, outAddr, outData} !== linkQ[0]) begin
        miscompares++;
        $display("wrong value at %0t: got %h expected %h", $time, {outTag, outAddr, outData}, linkQ[0]);
      end
      if (linkQ.size() > 0) void'(linkQ.pop_front());
    end
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  task print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ********************
  // tests
  // ********************
  initial begin
    {reset, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = {3'b100, 68'h0};
    {inTag, rdWord} = 21'h0;
    v = $urandom(81);
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(OUT_TAG_ADDR, {27'h0, TAG_RST}, '1);
    rd(OUT_CMD_ADDR_ADDR, {24'h0, CMD_ADDR_RST}, '1);
    rd(OUT_CMD_DATA_ADDR, {16'h0, CMD_DATA_RST}, '1);
    rd(IN_TAG_ADDR, ZERO_WORD, '1);
    rd(LINK_CONTROL_ADDR, ZERO_WORD, '1);
    rd(32'hfff09048, ZERO_WORD, '1);
    $display("reset values test done");
    for (int i = 0; i < 4; i++) begin
      v = $urandom & 32'h7fffffff;
      wr(OUT_CMD_ADDR_ADDR, v);
      wr(OUT_CMD_DATA_ADDR, ~v & 32'h7fffffff);
      wr(IN_TAG_ADDR, v);
      wr(32'hfff09048, v);
      rd(OUT_CMD_ADDR_ADDR, v & 32'hff, '1);
      rd(IN_TAG_ADDR, ZERO_WORD, '1);
      wr(OUT_CMD_DATA_ADDR, 32'h80000078);
      rd(OUT_CMD_DATA_ADDR, {16'h0, ~v[15:8], 8'h78}, '1);
    end
    $display("field access test done");
    for (int k = 0; k < 4; k++) begin
      inTag = 5'($urandom);
      rdWord = 16'($urandom);
      a = {k[0], 7'($urandom)};
      dw = 16'($urandom);
      t = {1'b1, 4'($urandom)};
      wr(OUT_CMD_ADDR_ADDR, {24'hffffff, a});
      wr(OUT_CMD_DATA_ADDR, {16'h0, dw});
      linkQ.push_back({t, a, dw});
      wr(OUT_TAG_ADDR, {27'h7ffffff, t});
      rd(LINK_CONTROL_ADDR, 32'h8, 32'hffffffef);
      wr(OUT_TAG_ADDR, {27'h0, ~t});
      rd(OUT_TAG_ADDR, {27'h0, t}, '1);
      n = 0;
      do begin
        bus(1'b0, LINK_CONTROL_ADDR, 32'h0, 32'h0, 32'hffffffe7, v);
        n++;
      end while ((v[PENDING_BIT] !== 1'b0 || (k[0] && v[READY_BIT] !== 1'b1)) && n < 300);
      if (n >= 300) miscompares++;
      if (k[0]) begin
        rd(IN_READ_DATA_ADDR, {16'h0, rdWord}, '1);
        rd(LINK_CONTROL_ADDR, ZERO_WORD, '1);
      end
      c = frmCnt;
      while (frmCnt - c < 2) @(posedge sys_clk);
      rd(IN_TAG_ADDR, {27'h0, inTag}, '1);
      $display("command test %0d done", k);
    end
    avs_read <= 1'b0;
    @(posedge sys_clk);
    print_verdict();
  end
endmodule
